// >>> rtl/recip_div_cfg.svh
`ifndef RECIP_DIV_CFG_SVH
`define RECIP_DIV_CFG_SVH

// Operand, product and accumulator widths
`define RD_WORD_W      32
`define RD_PROD_W      64
`define RD_ACC_W       67
`define RD_EXT_LSB     64
`define RD_CNT_W       6
`define RD_SEED_W      6

// Target precision used to size the fixed iteration count
`define RD_PREC_BITS   32

// Iteration cap when stopping on tolerance
`define RD_MAX_ITER    16

// Smallest legal divisor (one half, signed fraction with 31 fraction bits)
`define RD_DIV_HALF    32'h4000_0000

// Two, at the scale of divisor times approximation (61 fraction bits)
`define RD_TWO_BX      64'h4000_0000_0000_0000

// Extended accumulator bits expected for the negated product
`define RD_EXT_ONES    3'h7

`endif

// >>> rtl/recip_div_pkg.sv
package recip_div_pkg;

   // Multiplier/accumulator operations; the sequencer issues all but MAC_SHR_ACC
   typedef enum logic [2:0] {
      MAC_IDLE,
      MAC_LOAD_TEMP,
      MAC_NEG_MUL,
      MAC_SHL_MUL,
      MAC_QUOT_MUL,
      MAC_SHR_ACC
   } mac_op_t;

   // Sequencer states
   typedef enum logic [2:0] {
      S_IDLE,
      S_LOAD,
      S_NEG,
      S_SHL,
      S_FIN
   } seq_state_t;

endpackage

// >>> rtl/recip_div_if.sv
`timescale 1ns/1ns
`include "recip_div_cfg.svh"

interface recip_div_if;

   recip_div_pkg::mac_op_t      op;
   logic [`RD_WORD_W-1:0]       first_operand_bus;
   logic [`RD_WORD_W-1:0]       second_operand_bus;
   logic [`RD_WORD_W-1:0]       temp;
   logic [`RD_ACC_W-1:0]        acc;
   logic [`RD_WORD_W-1:0]       y;

   // Control side: drives operation and operands
   modport sequencer (
      output op,
      output first_operand_bus,
      output second_operand_bus,
      input  temp,
      input  acc,
      input  y
   );

   // Datapath side: executes one operation per clock
   modport datapath (
      input  op,
      input  first_operand_bus,
      input  second_operand_bus,
      output temp,
      output acc,
      output y
   );

endinterface

// >>> rtl/recip_mac_datapath.sv
`timescale 1ns/1ns
`include "recip_div_cfg.svh"

module recip_mac_datapath (
   input  wire logic                 clk_in,
   input  wire logic                 arst_n_in,
   recip_div_if.datapath             mac,
   output logic [`RD_ACC_W-1:0]      acc_out,
   output logic                      acc_ext_ones_out
);

   // ***************************************************************
   // Product terms
   // ***************************************************************
   logic [`RD_WORD_W-1:0]  temp_q;
   logic [`RD_ACC_W-1:0]   acc_q;
   logic [`RD_WORD_W-1:0]  y_q;
   logic [`RD_PROD_W-1:0]  neg_prod;
   logic [`RD_PROD_W-1:0]  shl_prod;
   logic [`RD_PROD_W-1:0]  quot_prod;
   logic [`RD_WORD_W-1:0]  next_x;

   // Divisor times approximation, both positive
   assign neg_prod  = `RD_PROD_W'(mac.second_operand_bus) * `RD_PROD_W'(temp_q);
   // Fraction bits of the accumulator times approximation; ext bits ignored
   assign shl_prod  = `RD_PROD_W'(acc_q[`RD_EXT_LSB-1:`RD_WORD_W]) * `RD_PROD_W'(temp_q);
   // Dividend times converged reciprocal
   assign quot_prod = `RD_PROD_W'(mac.first_operand_bus) * `RD_PROD_W'(temp_q);

   // Left shift by one realigns after the fraction multiply; round on next bit
   assign next_x = shl_prod[`RD_PROD_W-2:`RD_WORD_W-1]
                 + {{(`RD_WORD_W-1){1'b0}}, shl_prod[`RD_WORD_W-2]};

   // ***************************************************************
   // Temporary register
   // ***************************************************************
   // Holds the approximation; only load and shifted multiply change it
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         temp_q <= '0;
      else if (mac.op == recip_div_pkg::MAC_LOAD_TEMP)
         temp_q <= mac.first_operand_bus;
      else if (mac.op == recip_div_pkg::MAC_SHL_MUL)
         temp_q <= next_x;
   end

   // ***************************************************************
   // Accumulator with three extended bits
   // ***************************************************************
   // Negated product is placed with bit 63 weighing one, so for legal
   // operands the sign fills bits 66..64 with ones and adding two is moot
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         acc_q <= '0;
      else if (mac.op == recip_div_pkg::MAC_NEG_MUL)
         acc_q <= -{1'b0, neg_prod, 2'b00};
      else if (mac.op == recip_div_pkg::MAC_SHR_ACC)
         acc_q <= {{`RD_WORD_W{acc_q[`RD_ACC_W-1]}},
                   acc_q[`RD_ACC_W-1:`RD_WORD_W]};
   end

   // ***************************************************************
   // Y register
   // ***************************************************************
   // Quotient with 30 fraction bits, same scale as the approximation
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         y_q <= '0;
      else if (mac.op == recip_div_pkg::MAC_QUOT_MUL)
         y_q <= quot_prod[`RD_PROD_W-1:`RD_WORD_W];
   end

   // Outputs straight from the registers
   assign mac.temp         = temp_q;
   assign mac.acc          = acc_q;
   assign mac.y            = y_q;
   assign acc_out          = acc_q;
   assign acc_ext_ones_out = (acc_q[`RD_ACC_W-1:`RD_EXT_LSB] == `RD_EXT_ONES);

endmodule

// >>> rtl/recip_div_sequencer.sv
`timescale 1ns/1ns
`include "recip_div_cfg.svh"


module recip_div_sequencer #(
   parameter int unsigned MAX_ITER  = `RD_MAX_ITER,
   parameter int unsigned PREC_BITS = `RD_PREC_BITS
) (
   input  wire logic                    clk_in,
   input  wire logic                    arst_n_in,
   recip_div_if.sequencer               mac,
   input  wire logic                    start_in,
   input  wire logic [`RD_WORD_W-1:0]   divisor_in,
   input  wire logic [`RD_WORD_W-1:0]   dividend_in,
   input  wire logic [`RD_WORD_W-1:0]   seed_in,
   input  wire logic [`RD_SEED_W-1:0]   seed_bits_in,
   input  wire logic                    fixed_count_in,
   input  wire logic [`RD_WORD_W-1:0]   tolerance_in,
   output logic                         busy_out,
   output logic                         done_out,
   output logic                         range_err_out,
   output logic [`RD_WORD_W-1:0]        quotient_out,
   output logic [`RD_WORD_W-1:0]        recip_out,
   output logic [`RD_CNT_W-1:0]         iter_out
);

   // ***************************************************************
   // Fixed iteration count
   // ***************************************************************
   // Smallest count k with k*(2m+1) >= precision, never below one;
   // a constant-bound loop keeps this free of a real divider
   function automatic logic [`RD_CNT_W-1:0] fixed_iters(input logic [`RD_SEED_W-1:0] m);
      logic [`RD_CNT_W-1:0] n;
      int                   w;
      n = `RD_CNT_W'(PREC_BITS);
      w = 2 * int'(m) + 1;
      for (int k = PREC_BITS; k >= 1; k--)
      begin
         if (k * w >= int'(PREC_BITS))
            n = `RD_CNT_W'(k);
      end
      return n;
   endfunction

   // ***************************************************************
   // Operand checks at start
   // ***************************************************************
   logic [`RD_PROD_W-1:0] seed_prod;
   logic                  div_ok;
   logic                  seed_ok;
   logic                  start_ok;

   // Reject rather than iterate: an illegal pair diverges silently
   assign seed_prod = `RD_PROD_W'(divisor_in) * `RD_PROD_W'(seed_in);
   assign div_ok    = (divisor_in >= `RD_DIV_HALF) && !divisor_in[`RD_WORD_W-1];
   assign seed_ok   = (seed_in != '0) && (seed_prod < `RD_TWO_BX);
   assign start_ok  = div_ok && seed_ok;

   // ***************************************************************
   // State and operand registers
   // ***************************************************************
   recip_div_pkg::seq_state_t   state_q;
   logic [`RD_WORD_W-1:0]       divisor_q;
   logic [`RD_WORD_W-1:0]       dividend_q;
   logic [`RD_WORD_W-1:0]       seed_q;
   logic [`RD_WORD_W-1:0]       tol_q;
   logic                        fixed_q;
   logic [`RD_CNT_W-1:0]        lim_q;
   logic [`RD_CNT_W-1:0]        count_q;
   logic [`RD_WORD_W-1:0]       prev_x_q;
   logic [`RD_WORD_W-1:0]       diff;
   logic                        stop;

   // Absolute difference of the two most recent approximations
   assign diff = (mac.temp >= prev_x_q) ? (mac.temp - prev_x_q) : (prev_x_q - mac.temp);

   // Decided in the first cycle of the next iteration, so the loop stays
   // at two clocks; on a stop the quotient multiply is issued instead of the negate
   assign stop = (count_q == lim_q)
               || (!fixed_q && (count_q != '0) && (diff <= tol_q));

   // Operand capture on an accepted start
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         divisor_q  <= '0;
         dividend_q <= '0;
         seed_q     <= '0;
         tol_q      <= '0;
         fixed_q    <= 1'b0;
         lim_q      <= '0;
      end
      else if (state_q == recip_div_pkg::S_IDLE && start_in && start_ok)
      begin
         divisor_q  <= divisor_in;
         dividend_q <= dividend_in;
         seed_q     <= seed_in;
         tol_q      <= tolerance_in;
         fixed_q    <= fixed_count_in;
         lim_q      <= fixed_count_in ? fixed_iters(seed_bits_in)
                                      : `RD_CNT_W'(MAX_ITER);
      end
   end

   // ***************************************************************
   // Sequence control
   // ***************************************************************
   // Iterations alternate negate and shift-multiply with no idle cycle
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         state_q <= recip_div_pkg::S_IDLE;
      else
      begin
         unique case (state_q)
            recip_div_pkg::S_IDLE:
               if (start_in && start_ok)
                  state_q <= recip_div_pkg::S_LOAD;
            recip_div_pkg::S_LOAD:
               state_q <= recip_div_pkg::S_NEG;
            recip_div_pkg::S_NEG:
               state_q <= stop ? recip_div_pkg::S_FIN : recip_div_pkg::S_SHL;
            recip_div_pkg::S_SHL:
               state_q <= recip_div_pkg::S_NEG;
            recip_div_pkg::S_FIN:
               state_q <= recip_div_pkg::S_IDLE;
         endcase
      end
   end

   // Iteration counter and previous approximation
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         count_q  <= '0;
         prev_x_q <= '0;
      end
      else if (state_q == recip_div_pkg::S_LOAD)
      begin
         count_q  <= '0;
         prev_x_q <= seed_q;
      end
      else if (state_q == recip_div_pkg::S_SHL)
      begin
         count_q  <= count_q + `RD_CNT_W'(1);
         prev_x_q <= mac.temp;
      end
   end

   // ***************************************************************
   // Operation issue
   // ***************************************************************
   // No add-two step: the negated product already carries the fraction
   always_comb
   begin
      mac.op = recip_div_pkg::MAC_IDLE;
      unique case (state_q)
         recip_div_pkg::S_LOAD:
            mac.op = recip_div_pkg::MAC_LOAD_TEMP;
         recip_div_pkg::S_NEG:
            mac.op = stop ? recip_div_pkg::MAC_QUOT_MUL
                          : recip_div_pkg::MAC_NEG_MUL;
         recip_div_pkg::S_SHL:
            mac.op = recip_div_pkg::MAC_SHL_MUL;
         recip_div_pkg::S_IDLE,
         recip_div_pkg::S_FIN:
            mac.op = recip_div_pkg::MAC_IDLE;
      endcase
   end

   // Divisor stays on the second bus for the whole run
   assign mac.second_operand_bus = divisor_q;
   // Seed while loading, dividend otherwise
   assign mac.first_operand_bus  = (state_q == recip_div_pkg::S_LOAD) ? seed_q : dividend_q;

   // ***************************************************************
   // Results
   // ***************************************************************
   logic                  done_q;
   logic                  err_q;
   logic [`RD_WORD_W-1:0] quot_q;
   logic [`RD_WORD_W-1:0] recip_q;
   logic [`RD_CNT_W-1:0]  iter_q;

   // Results stay until the next accepted start finishes
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         done_q  <= 1'b0;
         quot_q  <= '0;
         recip_q <= '0;
         iter_q  <= '0;
      end
      else
      begin
         done_q <= (state_q == recip_div_pkg::S_FIN);
         if (state_q == recip_div_pkg::S_FIN)
         begin
            quot_q  <= mac.y;
            recip_q <= mac.temp;
            iter_q  <= count_q;
         end
      end
   end

   // One-cycle error pulse for a rejected start
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         err_q <= 1'b0;
      else
         err_q <= (state_q == recip_div_pkg::S_IDLE) && start_in && !start_ok;
   end

   assign busy_out      = (state_q != recip_div_pkg::S_IDLE);
   assign done_out      = done_q;
   assign range_err_out = err_q;
   assign quotient_out  = quot_q;
   assign recip_out     = recip_q;
   assign iter_out      = iter_q;

endmodule

// >>> tb/recip_div_chk.sv
`timescale 1ns/1ns
`include "recip_div_cfg.svh"

module recip_div_chk (
   input wire logic                    clk_in,
   input wire logic                    arst_n_in,
   input wire recip_div_pkg::mac_op_t  op,
   input wire logic [`RD_WORD_W-1:0]   first_operand_bus,
   input wire logic [`RD_WORD_W-1:0]   second_operand_bus,
   input wire logic [`RD_WORD_W-1:0]   temp,
   input wire logic [`RD_ACC_W-1:0]    acc,
   input wire logic [`RD_WORD_W-1:0]   y
);
   logic [63:0]             bx;
   logic [63:0]             pp;
   logic [63:0]             qq;
   logic [`RD_ACC_W-1:0]    neg_val;
   logic [`RD_WORD_W-1:0]   shl_val;

   // ******************************************************
   // Reference arithmetic for each multiply operation
   // ******************************************************
   // Worked from the bus values of the issuing cycle
   assign bx      = 64'(second_operand_bus) * 64'(temp);
   assign neg_val = 67'h0 - {1'b0, bx, 2'b00};
   assign pp      = 64'(acc[63:32]) * 64'(temp);
   assign shl_val = pp[62:31] + {31'h0, pp[30]};
   assign qq      = 64'(first_operand_bus) * 64'(temp);

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   // ******************************************************
   // Iteration steps
   // ******************************************************
   // An iteration is the negated multiply followed at once by the shift
   sequence s_neg;
      op == recip_div_pkg::MAC_NEG_MUL;
   endsequence
   sequence s_iter;
      s_neg ##1 op == recip_div_pkg::MAC_SHL_MUL;
   endsequence

   AST_LOAD_TEMP: assert property (op == recip_div_pkg::MAC_LOAD_TEMP |=>
      temp == $past(first_operand_bus)) else $error("temp not loaded from bus");
   AST_NEG_ACC: assert property (s_neg |=> acc == $past(neg_val))
      else $error("negated product wrong");
   AST_EXT_ONES: assert property (op == recip_div_pkg::MAC_NEG_MUL && temp != '0
      && second_operand_bus != '0 && !second_operand_bus[31] |=> acc[66:64] == `RD_EXT_ONES)
      else $error("extended bits not all ones");
   AST_SHL_TEMP: assert property (op == recip_div_pkg::MAC_SHL_MUL |=>
      temp == $past(shl_val)) else $error("shifted product wrong");
   AST_ITER_PAIR: assert property (s_neg |-> s_iter)
      else $error("negated multiply not followed by shift");
   AST_NO_ADD_STEP: assert property (op == recip_div_pkg::MAC_SHL_MUL |->
      $past(op) == recip_div_pkg::MAC_NEG_MUL) else $error("step between multiplies");
   AST_TEMP_HELD: assert property (s_neg |=> $stable(temp))
      else $error("approximation moved in first cycle");
   AST_DIV_STEADY: assert property (op == recip_div_pkg::MAC_SHL_MUL |->
      $stable(second_operand_bus)) else $error("divisor moved in iteration");
   AST_QUOT: assert property (op == recip_div_pkg::MAC_QUOT_MUL |=>
      y == $past(qq[63:32])) else $error("quotient product wrong");
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ns
`include "recip_div_cfg.svh"

module tb;
   logic                      clk_in       = 1'b0;
   logic                      arst_n_in    = 1'b0;
   logic                      start_in     = 1'b0;
   logic                      fixed_count_in = 1'b0;
   logic [`RD_WORD_W-1:0]     divisor_in   = 32'h0;
   logic [`RD_WORD_W-1:0]     dividend_in  = 32'h0;
   logic [`RD_WORD_W-1:0]     seed_in      = 32'h0;
   logic [`RD_WORD_W-1:0]     tolerance_in = 32'h0;
   logic [`RD_SEED_W-1:0]     seed_bits_in = 6'h0;
   logic                      busy_out;
   logic                      done_out;
   logic                      range_err_out;
   logic [`RD_WORD_W-1:0]     quotient_out;
   logic [`RD_WORD_W-1:0]     recip_out;
   logic [`RD_CNT_W-1:0]      iter_out;
   int                        error_cnt    = 0;
   int                        n_tests      = 0;

   // Clock, 50 ns period
   always #25 clk_in = ~clk_in;

   recip_div_if mac ();
   recip_mac_datapath i_recip_mac_datapath (.clk_in, .arst_n_in, .mac(mac),
      .acc_out(), .acc_ext_ones_out());
   recip_div_sequencer i_recip_div_sequencer (.clk_in, .arst_n_in, .mac(mac), .start_in,
      .divisor_in, .dividend_in, .seed_in, .seed_bits_in, .fixed_count_in, .tolerance_in,
      .busy_out, .done_out, .range_err_out, .quotient_out, .recip_out, .iter_out);
   recip_div_chk i_recip_div_chk (.clk_in, .arst_n_in, .op(mac.op),
      .first_operand_bus(mac.first_operand_bus), .second_operand_bus(mac.second_operand_bus),
      .temp(mac.temp), .acc(mac.acc), .y(mac.y));

   // Second datapath driven by the bench alone: the sequencer never issues
   // the accumulator right shift, so this is the only place it is exercised
   recip_div_if dp ();
   logic [`RD_ACC_W-1:0]      dp_acc_out;
   logic                      dp_ext_ones_out;
   recip_mac_datapath i_recip_mac_datapath_shr (.clk_in, .arst_n_in, .mac(dp),
      .acc_out(dp_acc_out), .acc_ext_ones_out(dp_ext_ones_out));

   // ******************************************************
   // Compare and closing tasks
   // ******************************************************
   task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_b(input logic got, input logic exp);
      cmp_w({31'h0, got}, {31'h0, exp});
   endtask

   task automatic conclude();
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ******************************************************
   // Expectation model
   // ******************************************************
   // One iteration: negate B*X, then shift the product back left by one
   function automatic logic [31:0] step(input logic [31:0] b, input logic [31:0] x);
      logic [63:0] p;
      logic [66:0] a;
      p = 64'(b) * 64'(x);
      a = 67'h0 - {1'b0, p, 2'b00};
      p = 64'(a[63:32]) * 64'(x);
      return p[62:31] + {31'h0, p[30]};
   endfunction

   // Fixed count rounded up so the precision target is never missed
   function automatic int nfix(input int m);
      return (m == 0) ? 32 : (32 + 2 * m) / (2 * m + 1);
   endfunction

   // Full division run, entered at a falling edge
   task automatic run(input logic [31:0] b, input logic [31:0] a, input logic [31:0] x0,
                      input logic [5:0] m, input logic fx, input logic [31:0] tol);
      logic [31:0] x;
      logic [31:0] xp;
      logic [63:0] q;
      int          n;
      int          cnt;
      xp = x0;
      n = 0;
      for (int k = 1; k <= 32 && n == 0; k++)
      begin
         x = step(b, xp);
         if (fx ? k == nfix(m) : (k == 16 || ((x > xp) ? x - xp : xp - x) <= tol))
            n = k;
         xp = x;
      end
      q = 64'(a) * 64'(xp);
      divisor_in = b;
      dividend_in = a;
      seed_in = x0;
      seed_bits_in = m;
      fixed_count_in = fx;
      tolerance_in = tol;
      start_in = 1'b1;
      cnt = 0;
      do
      begin
         @(negedge clk_in);
         cnt++;
         if (cnt == 1)
         begin
            start_in = 1'b0;
            cmp_b(busy_out, 1'b1);
         end
      end while (done_out !== 1'b1 && cnt < 100);
      cmp_w(32'(cnt), 32'(2 * n + 4));
      cmp_w(32'(iter_out), 32'(n));
      cmp_w(recip_out, xp);
      cmp_w(quotient_out, q[63:32]);
   endtask

   // Illegal operands are refused with a one-cycle error pulse
   task automatic bad(input logic [31:0] b, input logic [31:0] x0);
      divisor_in = b;
      seed_in = x0;
      start_in = 1'b1;
      @(negedge clk_in);
      start_in = 1'b0;
      cmp_b(range_err_out, 1'b1);
      cmp_b(busy_out, 1'b0);
      @(negedge clk_in);
      cmp_b(range_err_out, 1'b0);
      cmp_b(done_out, 1'b0);
   endtask

   // Load, negate, then arithmetic right shift by 32 of the accumulator;
   // operands must be a legal pair or both zero for the ones expectation
   task automatic shr_run(input logic [31:0] b, input logic [31:0] x);
      logic [66:0] a;
      a = 67'h0 - {1'b0, 64'(b) * 64'(x), 2'b00};
      dp.first_operand_bus = x;
      dp.second_operand_bus = b;
      dp.op = recip_div_pkg::MAC_LOAD_TEMP;
      @(negedge clk_in);
      dp.op = recip_div_pkg::MAC_NEG_MUL;
      @(negedge clk_in);
      dp.op = recip_div_pkg::MAC_SHR_ACC;
      cmp_b(dp_ext_ones_out, b != 32'h0 && x != 32'h0);
      @(negedge clk_in);
      dp.op = recip_div_pkg::MAC_IDLE;
      a = 67'($signed(a) >>> 32);
      cmp_w({29'h0, dp_acc_out[66:64]}, {29'h0, a[66:64]});
      cmp_w(dp_acc_out[63:32], a[63:32]);
      cmp_w(dp_acc_out[31:0], a[31:0]);
      @(negedge clk_in);
   endtask

   // ******************************************************
   // Main sequence
   // ******************************************************
   initial
   begin
      logic [31:0] b;
      logic [31:0] xs;
      void'($urandom(11655));
      dp.op = recip_div_pkg::MAC_IDLE;
      dp.first_operand_bus = 32'h0;
      dp.second_operand_bus = 32'h0;
      repeat (5) @(negedge clk_in);
      arst_n_in = 1'b1;
      run(32'h4000_0000, 32'hffff_ffff, 32'hffff_ffff, 6'h1, 1'b1, 32'h0);
      run(32'h7fff_ffff, 32'h8000_0000, 32'h4000_0000, 6'h0, 1'b1, 32'h0);
      run(32'h6000_0000, 32'h1234_5678, 32'h5555_0000, 6'h10, 1'b1, 32'h0);
      run(32'h4000_0000, 32'h9abc_def0, 32'h8000_0000, 6'h0, 1'b0, 32'h0);
      shr_run(32'h0, 32'h0);
      // Random legal operands, seed taken a little below the reciprocal
      for (int i = 0; i < 24; i++)
      begin
         b = {2'b01, 30'($urandom)};
         xs = 32'((64'h1 << 61) / 64'(b)) - 32'($urandom_range(0, 32'hff_ffff));
         run(b, $urandom, xs, 6'($urandom_range(0, 16)), 1'(i), 32'($urandom_range(0, 15)));
         shr_run(b, xs);
      end
      bad(32'h3fff_ffff, 32'h8000_0000);
      bad(32'h8000_0000, 32'h8000_0000);
      bad(32'h5000_0000, 32'h0);
      bad(32'h7fff_ffff, 32'h8000_0002);
      // Reset in mid-run must abandon the iteration
      divisor_in = 32'h5000_0000;
      seed_in = 32'h6666_0000;
      start_in = 1'b1;
      @(negedge clk_in);
      start_in = 1'b0;
      repeat (6) @(negedge clk_in);
      arst_n_in = 1'b0;
      @(negedge clk_in);
      cmp_b(busy_out, 1'b0);
      cmp_w({29'h0, mac.op}, {29'h0, recip_div_pkg::MAC_IDLE});
      arst_n_in = 1'b1;
      @(negedge clk_in);
      run(32'h5000_0000, 32'h0fed_cba9, 32'h6666_0000, 6'h3, 1'b1, 32'h0);
      conclude();
   end

   // Watchdog, far beyond the longest expected run
   initial
   begin
      #(50 * 20000);
      error_cnt++;
      conclude();
   end
endmodule
